// ### logic/rutc_pkg.sv
package rutc_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [15:0] ADDR_MODE = 16'hFFB4;
	localparam logic [15:0] ADDR_COUNT = 16'hFFB5;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'hFFB6;
	localparam logic [15:0] ADDR_IRQ_EN = 16'hFFB7;
	localparam logic [15:0] ADDR_EDGE_SEL = 16'hFFB8;
	localparam logic [15:0] ADDR_CLK_STOP = 16'hFFFA;

	// ****************************************
	// reset values and field positions
	// ****************************************
	localparam logic [7:0] MODE_RESET = 8'h18;
	localparam logic [7:0] MODE_RSVD_MASK = 8'h18;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] CLK_STOP_RESET = 8'hFF;
	localparam logic [7:0] EDGE_SEL_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_MIN = 8'h00;
	localparam logic [7:0] COUNT_STEP = 8'h01;
	localparam int RELOAD_MODE_POS = 7;
	localparam int DIR_HW_POS = 6;
	localparam int DIR_SW_POS = 5;
	localparam int CLK_SEL_MSB = 2;
	localparam int STANDBY_CTRL_POS = 1;
	localparam int EVENT_EDGE_POS = 1;
	localparam int OVF_FLAG_POS = 0;
	localparam int OVF_EN_POS = 0;

	// ****************************************
	// clock select codes and divider ratios
	// ****************************************
	localparam logic [2:0] CS_SUB_DIV4 = 3'h6;
	localparam logic [2:0] CS_EXT_EVENT = 3'h7;
	localparam int NUM_SYS_DIV = 6;
	localparam int PS_WIDTH = 13;
	// log2 of ratios 8192, 2048, 512, 64, 16, 4 for codes 0..5
	localparam int DIV_LOG2 [NUM_SYS_DIV] = '{13, 11, 9, 6, 4, 2};
	localparam logic [1:0] SUB_DIV_LAST = 2'h3;
endpackage : rutc_pkg

// ### logic/rutc_prescaler.sv
`timescale 1ns/1ns
module rutc_prescaler #(
	parameter int WIDTH = rutc_pkg::PS_WIDTH
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_run,
	output logic [rutc_pkg::NUM_SYS_DIV-1:0] o_tick
);
	import rutc_pkg::*;

	logic [WIDTH-1:0] ps_reg;
	logic [WIDTH-1:0] ps_next;

	// halted in module standby so it restarts from a known phase
	assign ps_next = i_run ? WIDTH'(ps_reg + 1'b1) : '0;

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			ps_reg <= '0;
		end else begin
			ps_reg <= ps_next;
		end
	end

	// one-cycle enable each time the low bits of the divider wrap
	genvar g;
	generate
		for (g = 0; g < NUM_SYS_DIV; g++) begin : g_tick
			assign o_tick[g] = i_run & (&ps_reg[DIV_LOG2[g]-1:0]);
		end
	endgenerate
endmodule : rutc_prescaler

// ### logic/rutc_timer.sv
// What this block does
// RULE_01 - eight-bit counter steps once per selected clock; interval and reload modes
// RULE_02 - mode bit 7: zero gives interval timer (reset), one auto-reload
// RULE_03 - bits 6:5: 00 up, 01 down, bit 6 set follows direction pin
// RULE_04 - hardware direction: pin high counts down, pin low counts up
// RULE_05 - select codes 0..4 pick clock divided by 8192, 2048, 512, 64, 16
// RULE_06 - code 5 clock/4, code 6 subclock/4, code 7 external event edges
// RULE_07 - event edge bit picks rising or falling edge of the event pin
// RULE_08 - software enables the event pin function before selecting code 7
// RULE_09 - mode bits 4 and 3 always read one; writes ignored
// RULE_10 - mode register at FFB4, read and write, resets to 18
// RULE_11 - FFB5 reads counter, writes reload; both reset to 00
// RULE_12 - counter overflow raises an interrupt request
// RULE_13 - in sub modes only subclock/4 or event clock may count
// RULE_14 - clock stop register at FFFA, read and write, resets to FF
// RULE_15 - FF up or 00 down overflows, sets flag; interval mode wraps
// RULE_16 - reload mode loads reload value on overflow or underflow
// RULE_17 - writing reload value also loads the counter at once
// RULE_18 - clock stop bit 1 zero halts the timer, one releases it
// RULE_19 - event pin is synchronised; one step per qualifying edge
// RULE_20 - interrupt asserted only while flag and enable are both one
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
module rutc_timer (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_event_in_pin,
	input wire logic i_dir_in_pin,
	input wire logic i_sub_clk,
	input wire logic i_sub_mode,
	output logic [7:0] o_rdata,
	output logic o_irq
);
	import rutc_pkg::*;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] timer_c_mode_reg;
	logic [7:0] timer_c_mode_next;
	logic [7:0] count_value_reg;
	logic [7:0] count_value_next;
	logic [7:0] reload_value_reg;
	logic [7:0] clock_stop_1_reg;
	logic [7:0] irq_edge_sel_reg;
	logic overflow_flag_reg;
	logic overflow_flag_next;
	logic overflow_int_enable_reg;
	logic overflow_int_enable_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic irq_reg;

	// ****************************************
	// address decode
	// ****************************************
	wire sel_mode = (i_addr == ADDR_MODE);
	wire sel_count = (i_addr == ADDR_COUNT);
	wire sel_stat = (i_addr == ADDR_IRQ_STAT);
	wire sel_en = (i_addr == ADDR_IRQ_EN);
	wire sel_edge = (i_addr == ADDR_EDGE_SEL);
	wire sel_ckstp = (i_addr == ADDR_CLK_STOP);
	wire wr_mode = i_wr & sel_mode;
	wire wr_count = i_wr & sel_count;
	wire wr_stat = i_wr & sel_stat;
	wire wr_en = i_wr & sel_en;
	wire wr_edge = i_wr & sel_edge;
	wire wr_ckstp = i_wr & sel_ckstp;

	// ****************************************
	// mode fields
	// ****************************************
	wire reload_mode_bit = timer_c_mode_reg[RELOAD_MODE_POS];
	wire dir_hw_select_bit = timer_c_mode_reg[DIR_HW_POS];
	wire dir_sw_bit = timer_c_mode_reg[DIR_SW_POS];
	wire [2:0] clock_sel_field = timer_c_mode_reg[CLK_SEL_MSB:0];
	wire standby_ctrl_bit = clock_stop_1_reg[STANDBY_CTRL_POS];
	wire event_edge_bit = irq_edge_sel_reg[EVENT_EDGE_POS];
	wire run = standby_ctrl_bit; // RULE_18
	// bit 6 set hands the direction to the pin; bit 5 then ignored
	wire count_down = dir_hw_select_bit ? i_dir_in_pin : dir_sw_bit; // RULE_03 RULE_04

	// ****************************************
	// clock sources
	// ****************************************
	logic [NUM_SYS_DIV-1:0] sys_tick;

	rutc_prescaler #(
		.WIDTH(PS_WIDTH)
	) u_prescaler (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_run(run),
		.o_tick(sys_tick)
	);

	// subclock is free running and unrelated to the system clock, so it is
	// synchronised; the count may therefore jitter by one system clock
	logic sub_s1_reg;
	logic sub_s2_reg;
	logic sub_s3_reg;
	logic [1:0] sub_div_reg;
	wire sub_rise = sub_s2_reg & ~sub_s3_reg;
	wire sub_tick = sub_rise & (sub_div_reg == SUB_DIV_LAST);

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			sub_s1_reg <= 1'b0;
			sub_s2_reg <= 1'b0;
			sub_s3_reg <= 1'b0;
			sub_div_reg <= 2'h0;
		end else begin
			sub_s1_reg <= i_sub_clk;
			sub_s2_reg <= sub_s1_reg;
			sub_s3_reg <= sub_s2_reg;
			if (sub_rise) begin
				sub_div_reg <= 2'(sub_div_reg + 2'h1);
			end
		end
	end

	// event pin: two-stage synchroniser, edge taken after the second stage
	logic ev_s1_reg;
	logic ev_s2_reg;
	logic ev_s3_reg;
	wire ev_rise = ev_s2_reg & ~ev_s3_reg;
	wire ev_fall = ~ev_s2_reg & ev_s3_reg;
	wire ev_edge = event_edge_bit ? ev_rise : ev_fall; // RULE_07 RULE_19

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			ev_s1_reg <= 1'b0;
			ev_s2_reg <= 1'b0;
			ev_s3_reg <= 1'b0;
		end else begin
			ev_s1_reg <= i_event_in_pin;
			ev_s2_reg <= ev_s1_reg;
			ev_s3_reg <= ev_s2_reg;
		end
	end

	// ****************************************
	// count enable selection
	// ****************************************
	logic src_tick;
	always_comb begin
		if (clock_sel_field == CS_EXT_EVENT) begin
			src_tick = ev_edge; // RULE_06
		end else if (clock_sel_field == CS_SUB_DIV4) begin
			src_tick = sub_tick; // RULE_06
		end else begin
			src_tick = sys_tick[clock_sel_field]; // RULE_05 RULE_06
		end
	end

	// only the subclock and event sources survive in the sub modes
	wire sub_ok = (clock_sel_field == CS_SUB_DIV4)
		| (clock_sel_field == CS_EXT_EVENT);
	wire sub_allow = ~i_sub_mode | sub_ok; // RULE_13
	wire tick = src_tick & run & sub_allow; // RULE_01 RULE_18

	// ****************************************
	// counter
	// ****************************************
	wire at_limit = count_down ? (count_value_reg == COUNT_MIN)
		: (count_value_reg == COUNT_MAX);
	wire wrap = tick & at_limit; // RULE_15
	wire [7:0] wrap_value = count_down ? COUNT_MAX : COUNT_MIN;
	wire [7:0] step_value = count_down
		? 8'(count_value_reg - COUNT_STEP)
		: 8'(count_value_reg + COUNT_STEP);

	always_comb begin
		if (wr_count) begin
			count_value_next = i_wdata; // RULE_17
		end else if (wrap && reload_mode_bit) begin
			count_value_next = reload_value_reg; // RULE_16
		end else if (wrap) begin
			count_value_next = wrap_value; // RULE_15
		end else if (tick) begin
			count_value_next = step_value; // RULE_01
		end else begin
			count_value_next = count_value_reg;
		end
	end

	// reserved bits forced to one whatever is written
	assign timer_c_mode_next = wr_mode ? (i_wdata | MODE_RSVD_MASK)
		: timer_c_mode_reg; // RULE_02 RULE_09

	// a wrap in the cycle of a clearing write still leaves the flag set
	assign overflow_flag_next = wrap
		| (overflow_flag_reg & ~(wr_stat & ~i_wdata[OVF_FLAG_POS])); // RULE_12

	// the request follows the enable written in the same cycle, so it never
	// outlives a cleared enable by one clock
	assign overflow_int_enable_next = wr_en ? i_wdata[OVF_EN_POS]
		: overflow_int_enable_reg; // RULE_20

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			timer_c_mode_reg <= MODE_RESET; // RULE_10
			count_value_reg <= COUNT_RESET; // RULE_11
			reload_value_reg <= RELOAD_RESET; // RULE_11
			clock_stop_1_reg <= CLK_STOP_RESET; // RULE_14
			irq_edge_sel_reg <= EDGE_SEL_RESET;
			overflow_flag_reg <= 1'b0;
			overflow_int_enable_reg <= 1'b0;
		end else begin
			timer_c_mode_reg <= timer_c_mode_next;
			count_value_reg <= count_value_next;
			overflow_flag_reg <= overflow_flag_next;
			if (wr_count) begin
				reload_value_reg <= i_wdata; // RULE_11
			end
			if (wr_ckstp) begin
				clock_stop_1_reg <= i_wdata; // RULE_14
			end
			if (wr_edge) begin
				irq_edge_sel_reg <= i_wdata;
			end
			overflow_int_enable_reg <= overflow_int_enable_next;
		end
	end

	// ****************************************
	// read path and interrupt
	// ****************************************
	wire [7:0] stat_view = {7'h00, overflow_flag_reg};
	wire [7:0] en_view = {7'h00, overflow_int_enable_reg};

	always_comb begin
		if (!i_rd) begin
			rdata_next = 8'h00;
		end else if (sel_mode) begin
			rdata_next = timer_c_mode_reg; // RULE_10
		end else if (sel_count) begin
			rdata_next = count_value_reg; // RULE_11
		end else if (sel_stat) begin
			rdata_next = stat_view;
		end else if (sel_en) begin
			rdata_next = en_view;
		end else if (sel_edge) begin
			rdata_next = irq_edge_sel_reg;
		end else if (sel_ckstp) begin
			rdata_next = clock_stop_1_reg; // RULE_14
		end else begin
			rdata_next = 8'h00;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			rdata_reg <= 8'h00;
			irq_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			irq_reg <= overflow_flag_next & overflow_int_enable_next; // RULE_20
		end
	end

	assign o_rdata = rdata_reg;
	assign o_irq = irq_reg;

	// ****************************************
	// assertions
	// ****************************************
	AST_INTERVAL_WRAP: assert property ( // RULE_15
		(tick && !wr_count && !reload_mode_bit && !count_down
			&& count_value_reg == 8'hFF)
		|=> (count_value_reg == 8'h00) && overflow_flag_reg)
		else $error("interval overflow did not wrap to 00");

	AST_RELOAD_LOAD: assert property ( // RULE_16
		(wrap && reload_mode_bit && !wr_count)
		|=> count_value_reg == $past(reload_value_reg))
		else $error("reload value not loaded on wrap");

	AST_WRITE_LOADS_COUNT: assert property ( // RULE_17
		wr_count |=> (count_value_reg == $past(i_wdata))
			&& (reload_value_reg == $past(i_wdata)))
		else $error("reload write did not load counter");

	AST_HW_DOWN: assert property ( // RULE_04
		(tick && !at_limit && !wr_count && dir_hw_select_bit
			&& i_dir_in_pin)
		|=> count_value_reg == 8'($past(count_value_reg) - 8'h01))
		else $error("pin high did not count down");

	AST_STANDBY_HALT: assert property ( // RULE_18
		(!standby_ctrl_bit && !wr_count) |=> $stable(count_value_reg))
		else $error("counter moved in module standby");

	AST_SUB_MODE_HALT: assert property ( // RULE_13
		(i_sub_mode && !sub_ok && !wr_count) |=> $stable(count_value_reg))
		else $error("counter moved on a blocked sub mode source");

	AST_RSVD_ONES: assert property ( // RULE_09
		timer_c_mode_reg[4:3] == 2'b11)
		else $error("reserved mode bits not one");

	AST_EVENT_ONLY_EDGE: assert property ( // RULE_19
		(clock_sel_field == CS_EXT_EVENT && !ev_edge && !wr_count)
		|=> $stable(count_value_reg))
		else $error("event counter moved without an edge");

	AST_FLAG_ON_WRAP: assert property ( // RULE_12
		wrap |=> overflow_flag_reg)
		else $error("overflow flag not set on wrap");

	AST_IRQ_GATE: assert property ( // RULE_20
		o_irq |-> overflow_flag_reg && overflow_int_enable_reg)
		else $error("interrupt without flag and enable");

	AST_MODE_READ: assert property ( // RULE_10
		(i_rd && sel_mode) |=> o_rdata == $past(timer_c_mode_reg))
		else $error("mode read data wrong");

	AST_IRQ_FOLLOWS: assert property ( // RULE_20
		(overflow_flag_reg && overflow_int_enable_reg) |-> o_irq)
		else $error("flag and enable set without interrupt");

	AST_FLAG_CLEAR: assert property ( // RULE_12
		(wr_stat && !i_wdata[OVF_FLAG_POS] && !wrap)
		|=> !overflow_flag_reg)
		else $error("overflow flag not cleared by write of zero");

	AST_UNDERFLOW_WRAP: assert property ( // RULE_15
		(tick && !wr_count && !reload_mode_bit && count_down
			&& count_value_reg == 8'h00)
		|=> (count_value_reg == 8'hFF) && overflow_flag_reg)
		else $error("interval underflow did not wrap to FF");

	AST_SW_UP: assert property ( // RULE_03
		(tick && !at_limit && !wr_count && !dir_hw_select_bit
			&& !dir_sw_bit)
		|=> count_value_reg == 8'($past(count_value_reg) + 8'h01))
		else $error("software up direction did not count up");

	AST_RELOAD_HOLD: assert property ( // RULE_11
		!wr_count |=> $stable(reload_value_reg))
		else $error("reload value changed without a write");
endmodule : rutc_timer

// ### sim/rutc_event_partner.sv
`timescale 1ns/1ns
module rutc_event_partner (
	input wire logic i_ref_clk,
	output logic o_event,
	output logic o_dir,
	output logic o_sub_clk
);
	initial begin
		o_event = 1'b0;
		o_dir = 1'b0;
		o_sub_clk = 1'b0;
	end

	// ****************************************
	// subclock crystal: free running, no phase tie to the system clock
	// ****************************************
	always #385 o_sub_clk = ~o_sub_clk;

	// ****************************************
	// event and direction pins
	// ****************************************
	// each level is held four cycles so the two-flop synchroniser cannot miss it
	task automatic drive_event(input logic lvl);
		@(posedge i_ref_clk);
		o_event <= lvl;
		repeat (4) @(posedge i_ref_clk);
	endtask : drive_event

	task automatic pulse(input int n);
		for (int k = 0; k < n; k++) begin
			drive_event(1'b1);
			drive_event(1'b0);
		end
	endtask : pulse

	task automatic set_dir(input logic lvl);
		@(posedge i_ref_clk);
		o_dir <= lvl;
	endtask : set_dir
endmodule : rutc_event_partner

// ### sim/rutc_timer_tb_top.sv
`timescale 1ns/1ns
module rutc_timer_tb_top;
	import rutc_pkg::*;
	logic i_ref_clk;
	logic i_reset;
	logic [15:0] i_addr;
	logic [7:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic i_sub_mode;
	logic ev;
	logic dir;
	logic sclk;
	logic [7:0] o_rdata;
	logic o_irq;
	logic [7:0] r;
	logic [7:0] v;
	integer seed = 32'h3c9a;
	int num_errors = 0;
	int checked = 0;
	// last entry: four synced subclock edges are about 31 system cycles
	int ratio [7] = '{8192, 2048, 512, 64, 16, 4, 31};

	always #50 i_ref_clk = ~i_ref_clk;

	rutc_timer u_rutc_timer (
		.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_event_in_pin(ev),
		.i_dir_in_pin(dir), .i_sub_clk(sclk), .i_sub_mode(i_sub_mode),
		.o_rdata(o_rdata), .o_irq(o_irq)
	);
	rutc_event_partner u_rutc_event_partner (
		.i_ref_clk(i_ref_clk), .o_event(ev), .o_dir(dir), .o_sub_clk(sclk)
	);

	// ****************************************
	// checking and bus tasks
	// ****************************************
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [7:0] got, input logic [7:0] exp,
			input string msg);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd

	task automatic rdc(input logic [15:0] a, input logic [7:0] exp,
			input string msg);
		logic [7:0] d;
		rd(a, d);
		check(d, exp, msg);
	endtask : rdc

	// prescaler phase is unknown to the bench, so a rate is judged within one tick
	function automatic logic [7:0] in_band(input logic [7:0] c);
		return (c >= 8'h03 && c <= 8'h05) ? 8'h01 : 8'h00;
	endfunction : in_band

	task automatic wait_irq(input logic lvl);
		#1;
		for (int k = 0; k < 8 && o_irq !== lvl; k++) begin
			@(posedge i_ref_clk);
			#1;
		end
		check({7'h00, o_irq}, {7'h00, lvl}, "irq level");
		if (o_irq !== lvl) begin
			final_report();
		end
	endtask : wait_irq

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		i_ref_clk = 1'b0;
		i_reset = 1'b1;
		i_addr = 16'h0000;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_sub_mode = 1'b0;
		repeat (16) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		rdc(ADDR_MODE, MODE_RESET, "mode reset");
		rdc(ADDR_COUNT, COUNT_RESET, "count reset");
		rdc(ADDR_CLK_STOP, CLK_STOP_RESET, "stop reset");
		rdc(16'hFFB9, 8'h00, "unmapped read");
		check({7'h00, o_irq}, 8'h00, "irq reset");
		$display("test reset done");
		// event clock with a quiet pin keeps the count still while checking
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed)) | 8'h07;
			r = 8'($random(seed));
			wr(ADDR_MODE, v);
			rdc(ADDR_MODE, v | MODE_RSVD_MASK, "mode rw");
			wr(ADDR_COUNT, r);
			rdc(ADDR_COUNT, r, "reload loads count");
			wr(ADDR_CLK_STOP, ~r);
			rdc(ADDR_CLK_STOP, ~r, "stop rw");
		end
		wr(ADDR_CLK_STOP, CLK_STOP_RESET);
		$display("test registers done");
		for (int c = 0; c < 7; c++) begin
			wr(ADDR_MODE, 8'(c));
			wr(ADDR_COUNT, 8'h00);
			repeat (4 * ratio[c]) @(posedge i_ref_clk);
			rd(ADDR_COUNT, r);
			check(in_band(r), 8'h01, "clock rate");
		end
		$display("test clock select done");
		i_sub_mode <= 1'b1;
		wr(ADDR_MODE, 8'h05);
		wr(ADDR_COUNT, 8'h00);
		repeat (64) @(posedge i_ref_clk);
		rdc(ADDR_COUNT, 8'h00, "sub mode halt");
		wr(ADDR_MODE, {5'h00, CS_SUB_DIV4});
		wr(ADDR_COUNT, 8'h00);
		repeat (124) @(posedge i_ref_clk);
		rd(ADDR_COUNT, r);
		check(in_band(r), 8'h01, "sub mode run");
		i_sub_mode <= 1'b0;
		wr(ADDR_MODE, 8'h05);
		wr(ADDR_CLK_STOP, 8'hFD);
		wr(ADDR_COUNT, 8'h00);
		repeat (64) @(posedge i_ref_clk);
		rdc(ADDR_COUNT, 8'h00, "standby frozen");
		wr(ADDR_CLK_STOP, CLK_STOP_RESET);
		$display("test sub mode and standby done");
		wr(ADDR_EDGE_SEL, 8'h02);
		wr(ADDR_MODE, {5'h00, CS_EXT_EVENT});
		wr(ADDR_COUNT, 8'h10);
		u_rutc_event_partner.pulse(3);
		rdc(ADDR_COUNT, 8'h13, "event count");
		u_rutc_event_partner.drive_event(1'b1);
		rdc(ADDR_COUNT, 8'h14, "rising counted");
		u_rutc_event_partner.drive_event(1'b0);
		rdc(ADDR_COUNT, 8'h14, "falling ignored");
		wr(ADDR_EDGE_SEL, 8'h00);
		u_rutc_event_partner.drive_event(1'b1);
		rdc(ADDR_COUNT, 8'h14, "rising ignored");
		u_rutc_event_partner.drive_event(1'b0);
		rdc(ADDR_COUNT, 8'h15, "falling counted");
		wr(ADDR_EDGE_SEL, 8'h02);
		$display("test events done");
		wr(ADDR_COUNT, 8'hFF);
		u_rutc_event_partner.pulse(1);
		rdc(ADDR_COUNT, 8'h00, "wrap up");
		rdc(ADDR_IRQ_STAT, 8'h01, "flag set");
		check({7'h00, o_irq}, 8'h00, "irq masked");
		wr(ADDR_IRQ_EN, 8'h01);
		wait_irq(1'b1);
		wr(ADDR_IRQ_STAT, 8'h00);
		wait_irq(1'b0);
		wr(ADDR_MODE, 8'h27);
		wr(ADDR_COUNT, 8'h01);
		u_rutc_event_partner.pulse(2);
		rdc(ADDR_COUNT, 8'hFF, "wrap down");
		wait_irq(1'b1);
		wr(ADDR_IRQ_STAT, 8'h00);
		$display("test interval wrap done");
		wr(ADDR_MODE, 8'h87);
		r = 8'($random(seed));
		wr(ADDR_COUNT, r);
		u_rutc_event_partner.pulse(256 - int'(r));
		rdc(ADDR_COUNT, r, "reload up");
		wr(ADDR_MODE, 8'hA7);
		wr(ADDR_COUNT, 8'h02);
		u_rutc_event_partner.pulse(3);
		rdc(ADDR_COUNT, 8'h02, "reload down");
		$display("test auto reload done");
		wr(ADDR_MODE, 8'h47);
		u_rutc_event_partner.set_dir(1'b1);
		wr(ADDR_COUNT, 8'h05);
		u_rutc_event_partner.pulse(1);
		rdc(ADDR_COUNT, 8'h04, "pin high down");
		u_rutc_event_partner.set_dir(1'b0);
		u_rutc_event_partner.pulse(1);
		rdc(ADDR_COUNT, 8'h05, "pin low up");
		wr(ADDR_MODE, 8'h67);
		u_rutc_event_partner.pulse(1);
		rdc(ADDR_COUNT, 8'h06, "bit 5 ignored");
		$display("test hardware direction done");
		final_report();
	end
endmodule : rutc_timer_tb_top
